// file: eep_pkg.sv
// constants shared by the serial eeprom front end
package eep_pkg;

    // ------------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_SET_LATCH = 8'h06;
    localparam logic [7:0] CMD_CLEAR_LATCH = 8'h04;
    localparam logic [7:0] CMD_STATUS_FETCH = 8'h05;
    localparam logic [7:0] CMD_STATUS_STORE = 8'h01;
    localparam logic [7:0] CMD_ARRAY_FETCH = 8'h03;
    localparam logic [7:0] CMD_ARRAY_STORE = 8'h02;
    localparam logic [7:0] CMD_IDPAGE_FETCH = 8'h83;
    localparam logic [7:0] CMD_IDPAGE_STORE = 8'h82;

    // ------------------------------------------------------------------
    // status register layout and reset values
    // ------------------------------------------------------------------
    localparam int BIT_BUSY = 0;
    localparam int BIT_WEL = 1;
    localparam int BIT_GUARD_LO = 2;
    localparam int BIT_GUARD_HI = 3;
    localparam int BIT_LOCK = 7;
    localparam logic RST_WEL = 1'b0;
    localparam logic [1:0] RST_GUARD = 2'h0;
    localparam logic RST_LOCK = 1'b0;

    // ------------------------------------------------------------------
    // block guard codes
    // ------------------------------------------------------------------
    localparam logic [1:0] GUARD_QUARTER = 2'h1;
    localparam logic [1:0] GUARD_HALF = 2'h2;
    localparam logic [1:0] GUARD_ALL = 2'h3;

    // ------------------------------------------------------------------
    // framing counts, in bytes, and the last bit index within a byte
    // ------------------------------------------------------------------
    localparam logic [2:0] BYTES_SAT = 3'h7;
    localparam logic [2:0] STORE_MIN_BYTES = 3'h2;
    localparam logic [2:0] ARRAY_MIN_BYTES = 3'h5;
    localparam logic [2:0] STATUS_DATA_AT = 3'h1;
    localparam logic [2:0] ARRAY_DATA_AT = 3'h4;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // ------------------------------------------------------------------
    // misc
    // ------------------------------------------------------------------
    localparam logic [7:0] FILL_BYTE = 8'hFF;
    localparam int unsigned WRITE_CYCLES = 1000;

endpackage

// file: eep_wc_if.sv
// write cycle control bundle between front end and timer
`timescale 1ns/1ns
interface eep_wc_if;
    logic start;
    logic busy;
    logic done;
    modport ctl (output start, input busy, input done);
    modport tmr (input start, output busy, output done);
endinterface

// file: eep_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ns
module eep_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and control
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_en,
    // data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta <= RST_VAL;
            o_q <= RST_VAL;
        end else if (i_en) begin
            meta <= i_d;
            o_q <= meta;
        end
    end
endmodule

// file: eep_wcycle.sv
// internal write cycle timer
`timescale 1ns/1ns
module eep_wcycle #(
    parameter int unsigned CYCLES = eep_pkg::WRITE_CYCLES
) (
    // clock and control
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_en,
    // cycle control
    eep_wc_if.tmr wc
);
    localparam logic [31:0] LAST = 32'(CYCLES - 1);
    logic [31:0] count;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            count <= 32'h0000_0000;
            wc.busy <= 1'b0;
            wc.done <= 1'b0;
        end else if (i_en) begin
            wc.done <= 1'b0;
            if (wc.start && !wc.busy) begin
                wc.busy <= 1'b1;
                count <= 32'h0000_0000;
            end else if (wc.busy) begin
                if (count == LAST) begin
                    wc.busy <= 1'b0;
                    wc.done <= 1'b1;
                end else begin
                    count <= count + 32'h0000_0001;
                end
            end
        end
    end
endmodule

// file: eep_spi_slave.sv
// serial eeprom front end: framing, hold, status register and protection
// Operation
// - chip select low selects; high deselects and floats the data output.
// - deselected part goes to standby only when no write cycle runs.
// - modes 0 and 3; sample on rising edge, drive from falling edge.
// - hold low with clock low pauses; output floats, inputs ignored.
// - hold high with clock low resumes the interrupted transfer.
// - deselect during pause abandons the paused command.
// - after power-up nothing starts until a chip select falling edge.
// - write commands need latch, whole bytes, data byte, boundary end.
// - chip select rising off a byte boundary discards a write.
// - read commands shift data out until chip select rises.
// - status bits six to four always read zero.
// - busy reads one from write decode until the cycle completes.
// - write commands execute only while the enable latch is set.
// - latch set by set command; cleared by clear, write end, power-up.
// - guard bits cleared by reset, else changed only by unprotected status store.
// - guard code selects none, upper quarter, upper half or everything.
// - lock bit zero leaves status writable whatever the protect pin.
// - lock one and protect pin low discards status stores.
// - protected state entered either order, left only by raising pin or reset.
// - unknown instruction makes the part ignore input until deselect.
// - status store updates only lock and guard, after its write cycle.
// - status can be read at any time, even during a write cycle.
`timescale 1ns/1ns
module eep_spi_slave #(
    parameter int unsigned P_WRITE_CYCLES = eep_pkg::WRITE_CYCLES
) (
    // system clock and control
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // serial link
    input wire logic i_spi_clk,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_hold_n,
    output logic o_so,
    output logic o_so_oe_n,
    // protection pin
    input wire logic i_wp_n,
    // status view
    output logic o_standby,
    output logic [7:0] o_status
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    eep_wc_if wc ();

    logic cs_s;
    logic wp_s;
    logic cs_d;
    logic armed;
    logic write_enable_latch;
    logic [1:0] guard;
    logic lock;
    logic pend_status;
    logic [7:0] pend_val;
    logic [7:0] status_word;
    logic [7:0] stat_l;

    logic fresh;
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [6:0] sh;
    logic [7:0] opcode;
    logic [16:0] addr;
    logic [7:0] data0;
    logic invalid;
    logic frame_ok;
    logic [7:0] tx;

    function automatic logic op_known(input logic [7:0] op);
        return op == eep_pkg::CMD_SET_LATCH
            || op == eep_pkg::CMD_CLEAR_LATCH
            || op == eep_pkg::CMD_STATUS_FETCH
            || op == eep_pkg::CMD_STATUS_STORE
            || op == eep_pkg::CMD_ARRAY_FETCH
            || op == eep_pkg::CMD_ARRAY_STORE
            || op == eep_pkg::CMD_IDPAGE_FETCH
            || op == eep_pkg::CMD_IDPAGE_STORE;
    endfunction

    function automatic logic op_addressed(input logic [7:0] op);
        return op == eep_pkg::CMD_ARRAY_FETCH
            || op == eep_pkg::CMD_ARRAY_STORE
            || op == eep_pkg::CMD_IDPAGE_FETCH
            || op == eep_pkg::CMD_IDPAGE_STORE;
    endfunction

    // ------------------------------------------------------------------
    // link side: frame clear and input shifting
    // ------------------------------------------------------------------
    // clock edges before select or while unarmed still clock the counters, each restarting them from zero
    wire frame_clr = i_cs_n | ~armed;
    wire float_req = frame_clr | ~i_hold_n;
    wire [2:0] bit_now = fresh ? 3'h0 : bit_cnt;
    wire [2:0] byte_now = fresh ? 3'h0 : byte_cnt;
    wire [6:0] sh_now = fresh ? 7'h00 : sh;
    wire invalid_now = fresh ? 1'b0 : invalid;
    wire [7:0] op_now = fresh ? 8'h00 : opcode;
    wire [7:0] new_byte = {sh_now, i_si};
    wire byte_done = bit_now == eep_pkg::LAST_BIT;
    wire [2:0] byte_inc = (byte_now == eep_pkg::BYTES_SAT) ?
        eep_pkg::BYTES_SAT : byte_now + 3'h1;
    wire addr_op = op_addressed(op_now);
    wire [2:0] data_at = addr_op ? eep_pkg::ARRAY_DATA_AT :
        eep_pkg::STATUS_DATA_AT;
    wire take_input = byte_done && !invalid_now && byte_now != 3'h0;
    wire hold_cut = i_cs_n & ~i_hold_n;

    // deselect while paused spoils the frame until the next active edge
    always_ff @(posedge i_spi_clk or posedge hold_cut) begin
        if (hold_cut) begin
            frame_ok <= 1'b0;
        end else if (i_hold_n) begin
            frame_ok <= 1'b1;
        end
    end

    // fresh marks the first rising edge of a frame; set again by deselect
    always_ff @(posedge i_spi_clk or posedge frame_clr) begin
        if (frame_clr) begin
            fresh <= 1'b1;
        end else if (i_hold_n) begin
            fresh <= 1'b0;
        end
    end

    // held fields stay put after deselect so the system side can judge them
    always_ff @(posedge i_spi_clk) begin
        if (i_hold_n) begin
            bit_cnt <= bit_now + 3'h1;
            sh <= new_byte[6:0];
            byte_cnt <= byte_done ? byte_inc : byte_now;
            opcode <= (byte_done && byte_now == 3'h0) ? new_byte : op_now;
            invalid <= (byte_done && byte_now == 3'h0) ?
                !op_known(new_byte) : invalid_now;
        end
    end

    always_ff @(posedge i_spi_clk) begin
        if (i_hold_n && take_input) begin
            if (addr_op && byte_now == 3'h1) begin
                addr[16] <= new_byte[0];
            end
            if (addr_op && byte_now == 3'h2) begin
                addr[15:8] <= new_byte;
            end
            if (addr_op && byte_now == 3'h3) begin
                addr[7:0] <= new_byte;
            end
            if (byte_now == data_at) begin
                data0 <= new_byte;
            end
        end
    end

    // ------------------------------------------------------------------
    // link side: output shifting
    // ------------------------------------------------------------------
    wire fetch_status = op_now == eep_pkg::CMD_STATUS_FETCH;
    wire fetch_addr = op_now == eep_pkg::CMD_ARRAY_FETCH
        || op_now == eep_pkg::CMD_IDPAGE_FETCH;
    wire rd_go = !fresh && !invalid_now
        && ((fetch_status && byte_now >= eep_pkg::STATUS_DATA_AT)
        || (fetch_addr && byte_now >= eep_pkg::ARRAY_DATA_AT));
    wire [7:0] rd_src = fetch_status ? stat_l : eep_pkg::FILL_BYTE;
    // bit chosen by position, so a repeated falling edge cannot skip one
    wire tx_pick = tx[3'h7 - bit_now];
    wire next_so = (bit_now == 3'h0) ? rd_src[7] : tx_pick;

    eep_sync #(
        .W(8),
        .RST_VAL(8'h00)
    ) u_stat_sync (
        .i_clk(i_spi_clk),
        .i_rst(1'b0),
        .i_en(1'b1),
        .i_d(status_word),
        .o_q(stat_l)
    );

    // output floats at once on deselect, hold or before arming
    always_ff @(negedge i_spi_clk or posedge float_req) begin
        if (float_req) begin
            o_so_oe_n <= 1'b1;
            o_so <= 1'b0;
        end else begin
            o_so_oe_n <= ~rd_go;
            o_so <= next_so;
        end
    end

    // byte to send is kept through a pause
    always_ff @(negedge i_spi_clk) begin
        if (!float_req && bit_now == 3'h0) begin
            tx <= rd_src;
        end
    end

    // ------------------------------------------------------------------
    // system side: pin synchronisers and select tracking
    // ------------------------------------------------------------------
    eep_sync #(
        .W(2),
        // select reads low after reset so only a real high arms
        .RST_VAL(2'h1)
    ) u_pin_sync (
        .i_clk(i_sys_clk),
        .i_rst(i_sys_rst),
        .i_en(i_clk_en),
        .i_d({i_cs_n, i_wp_n}),
        .o_q({cs_s, wp_s})
    );

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            cs_d <= 1'b1;
            armed <= 1'b0;
        end else if (i_clk_en) begin
            cs_d <= cs_s;
            if (cs_s) begin
                armed <= 1'b1;
            end
        end
    end

    // link fields are quiet once the synchronised select has risen
    wire ev = cs_s && !cs_d && armed && i_clk_en;
    wire f_whole = bit_cnt == 3'h0;
    wire f_valid = frame_ok && !invalid;
    wire is_set = f_valid && opcode == eep_pkg::CMD_SET_LATCH;
    wire is_clear = f_valid && opcode == eep_pkg::CMD_CLEAR_LATCH;
    wire is_store = f_valid && opcode == eep_pkg::CMD_STATUS_STORE;
    wire is_idstore = f_valid && opcode == eep_pkg::CMD_IDPAGE_STORE;
    wire is_wstore = (f_valid && opcode == eep_pkg::CMD_ARRAY_STORE)
        || is_idstore;

    // ------------------------------------------------------------------
    // system side: command judgement
    // ------------------------------------------------------------------
    wire status_locked = lock && !wp_s;
    wire array_guarded = guard == eep_pkg::GUARD_ALL
        || (guard == eep_pkg::GUARD_HALF && addr[16])
        || (guard == eep_pkg::GUARD_QUARTER && addr[16] && addr[15]);
    wire wr_guarded = is_idstore ? guard == eep_pkg::GUARD_ALL :
        array_guarded;
    wire st_ok = is_store && f_whole && write_enable_latch && !wc.busy
        && byte_cnt >= eep_pkg::STORE_MIN_BYTES
        && !status_locked;
    wire wr_ok = is_wstore && f_whole && write_enable_latch && !wc.busy
        && byte_cnt >= eep_pkg::ARRAY_MIN_BYTES
        && !wr_guarded;
    wire set_hit = ev && is_set && byte_cnt != 3'h0;
    wire clear_hit = ev && is_clear && byte_cnt != 3'h0;
    assign wc.start = ev && (st_ok || wr_ok);

    eep_wcycle #(
        .CYCLES(P_WRITE_CYCLES)
    ) u_wcycle (
        .i_clk(i_sys_clk),
        .i_rst(i_sys_rst),
        .i_en(i_clk_en),
        .wc(wc)
    );

    // ------------------------------------------------------------------
    // system side: status register
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            write_enable_latch <= eep_pkg::RST_WEL;
            guard <= eep_pkg::RST_GUARD;
            lock <= eep_pkg::RST_LOCK;
            pend_status <= 1'b0;
            pend_val <= 8'h00;
        end else if (i_clk_en) begin
            if (set_hit) begin
                write_enable_latch <= 1'b1;
            end else if (clear_hit || wc.done) begin
                write_enable_latch <= 1'b0;
            end
            if (wc.start) begin
                pend_status <= st_ok;
                pend_val <= data0;
            end
            if (wc.done && pend_status) begin
                lock <= pend_val[eep_pkg::BIT_LOCK];
                guard <= {pend_val[eep_pkg::BIT_GUARD_HI],
                    pend_val[eep_pkg::BIT_GUARD_LO]};
            end
        end
    end

    always_comb begin
        status_word = 8'h00;
        status_word[eep_pkg::BIT_BUSY] = wc.busy;
        status_word[eep_pkg::BIT_WEL] = write_enable_latch;
        status_word[eep_pkg::BIT_GUARD_LO] = guard[0];
        status_word[eep_pkg::BIT_GUARD_HI] = guard[1];
        status_word[eep_pkg::BIT_LOCK] = lock;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_status <= 8'h00;
            o_standby <= 1'b0;
        end else if (i_clk_en) begin
            o_status <= status_word;
            o_standby <= cs_s && !wc.busy;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_commit;
        wc.done && pend_status;
    endsequence

    sequence s_store_go;
        wc.start && st_ok;
    endsequence

    a_status_zeros: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        status_word[6:4] == 3'h0)
        else $error("reserved status bits not zero");

    a_busy_from_start: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst || !i_clk_en)
        wc.start |=> wc.busy)
        else $error("busy not raised by write start");

    a_latch_gates_write: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        wc.start |-> write_enable_latch)
        else $error("write started without enable latch");

    a_latch_clear_end: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst || !i_clk_en)
        (wc.done && !set_hit) |=> !write_enable_latch)
        else $error("latch not cleared at write end");

    a_guard_change_src: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        !$stable(guard) |-> $past(wc.done && pend_status))
        else $error("guard changed outside status store");

    a_locked_discard: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (ev && is_store && lock && !wp_s) |-> !wc.start)
        else $error("status store accepted while locked");

    a_boundary_discard: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        (ev && bit_cnt != 3'h0) |-> !wc.start)
        else $error("write accepted off a byte boundary");

    a_unarmed_idle: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        !armed |-> !wc.start && !set_hit)
        else $error("command taken before first select edge");

    a_store_commit: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst || !i_clk_en)
        s_commit |=> lock == $past(pend_val[eep_pkg::BIT_LOCK]))
        else $error("lock bit not updated at store end");

    a_store_busy_run: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst || !i_clk_en)
        s_store_go |=> wc.busy [*2])
        else $error("busy dropped early after status store");

    a_busy_no_standby: assert property (
        @(posedge i_sys_clk) disable iff (i_sys_rst || !i_clk_en)
        wc.busy |=> !o_standby)
        else $error("standby entered during write cycle");

    a_hold_freezes: assert property (
        @(posedge i_spi_clk) disable iff (frame_clr)
        (!fresh && !i_hold_n) |=> $stable(bit_cnt) && $stable(byte_cnt))
        else $error("bit position moved during hold");

endmodule

// file: eep_spi_master_model.sv
// behavioural serial bus master facing the eeprom front end
`timescale 1ns/1ns
module eep_spi_master_model (
    // serial link
    output logic o_spi_clk,
    output logic o_cs_n,
    output logic o_si,
    output logic o_hold_n,
    input wire logic i_so,
    input wire logic i_so_oe_n
);
    logic mode3 = 1'b0;
    logic hold_float = 1'b0;

    // select already low at power-up on purpose
    initial begin
        o_cs_n = 1'b0;
        o_spi_clk = 1'b0;
        o_si = 1'b0;
        o_hold_n = 1'b1;
    end

    // one frame msb first, pause before bit hold_at; at nbits abort in pause
    task automatic xfer(input logic [63:0] tx, input int nbits,
                        input int hold_at, output logic [63:0] rx);
        rx = '0;
        #300;
        o_spi_clk = mode3;
        #8;
        o_cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            if (i == hold_at) begin
                o_spi_clk = 1'b0;
                #8 o_hold_n = 1'b0;
                o_si = ~o_si;
                #8 o_spi_clk = 1'b1;
                hold_float = i_so_oe_n;
                #8 o_hold_n = 1'b1;
                #8;
            end
            o_spi_clk = 1'b0;
            o_si = tx[nbits-1-i];
            #7 o_spi_clk = 1'b1;
            rx = {rx[62:0], i_so};
            #8;
        end
        #7 o_spi_clk = mode3;
        if (hold_at == nbits) begin
            o_hold_n = 1'b0;
            #8 o_cs_n = 1'b1;
            #8 o_hold_n = 1'b1;
        end else begin
            #8 o_cs_n = 1'b1;
        end
        o_si = ~o_si;
    endtask
endmodule

// file: eep_spi_slave_tb_top.sv
// self-checking bench for the serial eeprom front end
`timescale 1ns/1ns
module eep_spi_slave_tb_top;
    localparam int unsigned WC = 40;
    logic i_sys_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_clk_en = 1'b1;
    logic i_wp_n = 1'b1;
    logic spi_clk;
    logic cs_n;
    logic si;
    logic hold_n;
    logic so;
    logic so_oe_n;
    logic so_line;
    logic standby;
    logic [7:0] status;
    logic [63:0] rx;
    int miscompares = 0;
    int checked = 0;

    always #25 i_sys_clk = ~i_sys_clk;

    // floating output shows the inverse of its last value
    assign so_line = so_oe_n ? ~so : so;

    eep_spi_slave #(.P_WRITE_CYCLES(WC)) u_eep_spi_slave (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_spi_clk(spi_clk),
        .i_cs_n(cs_n),
        .i_si(si),
        .i_hold_n(hold_n),
        .o_so(so),
        .o_so_oe_n(so_oe_n),
        .i_wp_n(i_wp_n),
        .o_standby(standby),
        .o_status(status)
    );

    eep_spi_master_model u_eep_spi_master_model (
        .o_spi_clk(spi_clk),
        .o_cs_n(cs_n),
        .o_si(si),
        .o_hold_n(hold_n),
        .i_so(so_line),
        .i_so_oe_n(so_oe_n)
    );

    task automatic chk(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic frame(input logic [63:0] tx, input int n, input int h);
        u_eep_spi_master_model.xfer(tx, n, h, rx);
        repeat (6) @(posedge i_sys_clk);
        #1;
    endtask

    task automatic wait_cycle;
        repeat (WC + 8) @(posedge i_sys_clk);
        #1;
    endtask

    task automatic set_wp(input logic v);
        @(posedge i_sys_clk);
        #1 i_wp_n = v;
        repeat (4) @(posedge i_sys_clk);
    endtask

    task automatic test_powerup;
        chk("status", status, 8'h00);
        chk("oe_n", {7'h0, so_oe_n}, 8'h01);
        frame(64'h06, 8, 99);
        chk("status", status, 8'h00);
    endtask

    task automatic test_latch_read;
        frame(64'h06, 8, 99);
        chk("status", status, 8'h02);
        frame(64'h05_0000, 24, 99);
        chk("rd byte0", rx[15:8], 8'h02);
        chk("rd byte1", rx[7:0], 8'h02);
        chk("oe_n", {7'h0, so_oe_n}, 8'h01);
        frame(64'h05_0000, 24, 12);
        chk("hold float", {7'h0, u_eep_spi_master_model.hold_float},
            8'h01);
        chk("hold byte", rx[15:8], 8'h02);
        frame(64'h04, 8, 99);
        chk("status", status, 8'h00);
    endtask

    task automatic test_refused;
        frame(64'h018C, 16, 99);
        wait_cycle;
        chk("no latch", status, 8'h00);
        frame(64'h06, 8, 99);
        frame(64'h018C >> 1, 15, 99);
        wait_cycle;
        chk("off boundary", status, 8'h02);
        frame(64'h04, 8, 99);
        frame(64'h06, 8, 8);
        chk("hold abort", status, 8'h00);
    endtask

    task automatic test_store;
        u_eep_spi_master_model.mode3 = 1'b1;
        frame(64'h06, 8, 99);
        frame(64'h018C, 16, 99);
        chk("busy", {7'h0, status[0]}, 8'h01);
        chk("standby", {7'h0, standby}, 8'h00);
        frame(64'h05_00, 16, 99);
        chk("rd busy", rx[7:0], 8'h03);
        wait_cycle;
        chk("stored", status, 8'h8C);
        chk("standby", {7'h0, standby}, 8'h01);
        u_eep_spi_master_model.mode3 = 1'b0;
    endtask

    task automatic test_protect;
        set_wp(1'b0);
        frame(64'h06, 8, 99);
        frame(64'h0100, 16, 99);
        wait_cycle;
        chk("locked", status, 8'h8E);
        set_wp(1'b1);
        frame(64'h0100, 16, 99);
        wait_cycle;
        chk("unlocked", status, 8'h00);
        set_wp(1'b0);
        frame(64'h06, 8, 99);
        frame(64'h0104, 16, 99);
        wait_cycle;
        chk("lock clear", status, 8'h04);
        frame(64'hAA06, 16, 99);
        chk("unknown", status, 8'h04);
    endtask

    task automatic print_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // hang guard, well above the expected run time
    initial begin
        #200000;
        miscompares++;
        print_verdict;
    end

    initial begin
        repeat (6) @(posedge i_sys_clk);
        #1 i_sys_rst = 1'b0;
        repeat (2) @(posedge i_sys_clk);
        #1;
        test_powerup;
        test_latch_read;
        test_refused;
        test_store;
        test_protect;
        print_verdict;
    end
endmodule
